/* include/adcsr_pkg.sv */
package adcsr_pkg;
   // clock and timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int POR_TIME_NS = 500000;
   localparam int POR_CYC = POR_TIME_NS / CLK_PERIOD_NS;
   localparam int TEST_DELAY_NS = 26000;
   localparam int TEST_DELAY_CYC = (TEST_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // status test delay on the external oscillator, in tenths of a period, rounded up to whole ticks
   localparam int EXT_DELAY_TENTHS = 36;
   localparam int EXT_DELAY_TICKS = (EXT_DELAY_TENTHS + 9) / 10;
   localparam int TDLY_W = $clog2(TEST_DELAY_CYC + 1);
   // serial clock divider and frame
   localparam int SCK_DIV = 8;
   localparam int SCK_HALF = SCK_DIV / 2;
   localparam int DIV_W = $clog2(SCK_HALF);
   localparam int FRAME_BITS = 32;
   localparam int CNT_W = $clog2(FRAME_BITS + 1);
   localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(FRAME_BITS);
   localparam logic [CNT_W-1:0] PRE_LAST_BIT = CNT_W'(FRAME_BITS - 1);
   localparam logic [CNT_W-1:0] FIRST_BIT = CNT_W'(1);
   // levels
   localparam logic EOC_BUSY = 1'b1;
   localparam logic EOC_DONE = 1'b0;
   typedef enum logic [1:0] {
      ST_POR = 2'h2,
      ST_CONV = 2'h0,
      ST_SLEEP = 2'h1,
      ST_DOUT = 2'h3
   } adcsr_state_e;
endpackage

/* hw/adcsr_buf.sv */
module adcsr_buf #(
   parameter int WIDTH = 31,
   parameter int DEPTH = 2
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // fill side
   input wire logic in_valid_in,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic in_ready_out,
   // drain side
   output logic out_valid_out,
   output logic [WIDTH-1:0] out_data_out,
   input wire logic out_ready_in
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [PW-1:0] wr_ptr_r;
   logic [PW-1:0] rd_ptr_r;
   logic [CW-1:0] count_r;
   logic [CW-1:0] count_nxt;
   logic push;
   logic pop;

   if (DEPTH < 2) begin : g_chk
      $error("adcsr_buf needs at least two entries");
   end

   function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
      ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction

   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;
   assign out_data_out = mem_r[rd_ptr_r];

   always_comb begin
      count_nxt = count_r;
      if (push && !pop) begin
         count_nxt = count_r + CW'(1);
      end else if (pop && !push) begin
         count_nxt = count_r - CW'(1);
      end
   end

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
         in_ready_out <= 1'b0;
         out_valid_out <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_r <= ptr_inc(wr_ptr_r);
         end
         if (pop) begin
            rd_ptr_r <= ptr_inc(rd_ptr_r);
         end
         count_r <= count_nxt;
         in_ready_out <= (count_nxt != CW'(DEPTH));
         out_valid_out <= (count_nxt != '0);
      end
   end

   a_buf_bound: assert property (@(posedge clk_in) disable iff (rst_in) count_r <= CW'(DEPTH))
      else $error("buffer count above depth");
endmodule

/* hw/adcsr_readout.sv */
module adcsr_readout
   import adcsr_pkg::*;
#(
   parameter int POR_CYCLES = adcsr_pkg::POR_CYC,
   parameter int RESULT_W = adcsr_pkg::FRAME_BITS - 1,
   parameter int BUF_DEPTH = 2
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // serial link pins
   input wire logic cs_n_in,
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe_out,
   output logic sck_pullup_out,
   output logic sdo_out,
   output logic sdo_oe_out,
   // conversion clock source
   input wire logic rate_oscillator_pin_in,
   input wire logic conv_tick_in,
   // conversion core
   output logic conv_start_out,
   input wire logic result_valid_in,
   input wire logic [RESULT_W-1:0] result_data_in,
   output logic result_ready_out
);
   import adcsr_pkg::*;

   localparam int POR_W = $clog2(POR_CYCLES + 1);

   adcsr_state_e state_r;
   logic [POR_W-1:0] por_cnt_r;
   logic ext_mode_r;
   logic cs_q_r;
   logic sck_q_r;
   logic sck_drv_r;
   logic [DIV_W-1:0] div_r;
   logic [CNT_W-1:0] bit_cnt_r;
   logic [FRAME_BITS-1:0] shreg_r;
   logic [TDLY_W-1:0] tdly_r;
   logic sck_oe_r;
   logic buf_valid;
   logic [RESULT_W-1:0] buf_data;
   logic buf_ready;
   logic cs_fall;
   logic cs_rise;
   logic sck_lvl;
   logic sck_rise;
   logic sck_fall;
   logic por_done;
   logic conv_done;
   logic tdly_expired;
   logic int_tick;
   logic ext_end;
   logic int_end;
   logic abort;
   logic enter_conv;

   if (POR_CYCLES < 1 || RESULT_W != FRAME_BITS - 1 || BUF_DEPTH < 2) begin : g_chk
      $error("adcsr_readout parameters out of range");
   end

   function automatic logic edge_up(input logic prev, input logic cur);
      edge_up = !prev && cur;
   endfunction

   // result buffer between the conversion core and the shift register
   adcsr_buf #(
      .WIDTH(RESULT_W),
      .DEPTH(BUF_DEPTH)
   ) u_buf (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .in_valid_in(result_valid_in),
      .in_data_in(result_data_in),
      .in_ready_out(result_ready_out),
      .out_valid_out(buf_valid),
      .out_data_out(buf_data),
      .out_ready_in(buf_ready)
   );

   // edge detection on link pins
   assign cs_fall = edge_up(!cs_q_r, !cs_n_in);
   assign cs_rise = edge_up(cs_q_r, cs_n_in);
   assign sck_lvl = ext_mode_r ? sck_in : sck_drv_r;
   assign sck_rise = edge_up(sck_q_r, sck_lvl);
   assign sck_fall = edge_up(!sck_q_r, !sck_lvl);

   assign por_done = (state_r == ST_POR) && (por_cnt_r == POR_W'(POR_CYCLES - 1));
   assign buf_ready = (state_r == ST_CONV);
   assign conv_done = buf_ready && buf_valid;
   assign int_tick = conv_tick_in && (div_r == DIV_W'(SCK_HALF - 1));
   assign tdly_expired = rate_oscillator_pin_in ? (tdly_r >= TDLY_W'(EXT_DELAY_TICKS))
                                                 : (tdly_r >= TDLY_W'(TEST_DELAY_CYC));
   assign abort = (state_r == ST_DOUT) && cs_rise;
   assign ext_end = (state_r == ST_DOUT) && ext_mode_r && sck_fall && (bit_cnt_r == LAST_BIT);
   assign int_end = (state_r == ST_DOUT) && !ext_mode_r && sck_rise && (bit_cnt_r == PRE_LAST_BIT);
   assign enter_conv = por_done || abort || ext_end || int_end;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cs_q_r <= 1'b1;
         sck_q_r <= 1'b1;
      end else begin
         cs_q_r <= cs_n_in;
         sck_q_r <= sck_lvl;
      end
   end

   // power-on delay counter
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         por_cnt_r <= '0;
      end else if (state_r == ST_POR) begin
         por_cnt_r <= por_cnt_r + POR_W'(1);
      end
   end

   // clock mode selection
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ext_mode_r <= 1'b0;
      end else if (por_done) begin
         ext_mode_r <= !sck_in;
      end else if (cs_fall && state_r != ST_POR) begin
         ext_mode_r <= !sck_in;
      end
   end

   // conversion state machine
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state_r <= ST_POR;
      end else begin
         case (state_r)
            ST_POR: begin
               if (por_done) begin
                  state_r <= ST_CONV;
               end
            end
            ST_CONV: begin
               if (conv_done) begin
                  state_r <= ST_SLEEP;
               end
            end
            ST_SLEEP: begin
               if (sck_rise && !cs_n_in) begin
                  state_r <= ST_DOUT;
               end
            end
            ST_DOUT: begin
               if (abort) begin
                  state_r <= ST_CONV;
               end else if (ext_end || int_end) begin
                  state_r <= ST_CONV;
               end
            end
            default: state_r <= ST_POR;
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         conv_start_out <= 1'b0;
      end else begin
         conv_start_out <= enter_conv;
      end
   end

   // result shift register and bit counter
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         shreg_r <= '0;
      end else if (conv_done) begin
         shreg_r <= {EOC_DONE, buf_data};
      end else if (state_r == ST_DOUT && sck_fall) begin
         shreg_r <= {shreg_r[FRAME_BITS-2:0], 1'b0};
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         bit_cnt_r <= '0;
      end else if (state_r == ST_SLEEP && sck_rise && !cs_n_in) begin
         bit_cnt_r <= FIRST_BIT;
      end else if (state_r == ST_DOUT && sck_rise) begin
         bit_cnt_r <= bit_cnt_r + CNT_W'(1);
      end else if (state_r != ST_DOUT) begin
         bit_cnt_r <= '0;
      end
   end

   // status test delay, counted from chip-select fall or end of conversion
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         tdly_r <= '0;
      end else if (cs_n_in || state_r != ST_SLEEP || ext_mode_r) begin
         tdly_r <= '0;
      end else if (!tdly_expired && (conv_tick_in || !rate_oscillator_pin_in)) begin
         tdly_r <= tdly_r + TDLY_W'(1);
      end
   end

   // internal serial clock divider
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         div_r <= '0;
      end else if (state_r != ST_DOUT) begin
         div_r <= '0;
      end else if (conv_tick_in) begin
         div_r <= div_r + DIV_W'(1);
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         sck_drv_r <= 1'b1;
      end else if (cs_fall || conv_done) begin
         sck_drv_r <= 1'b0;
      end else if (state_r == ST_SLEEP && !ext_mode_r && !cs_n_in && tdly_expired) begin
         sck_drv_r <= 1'b1;
      end else if (state_r == ST_DOUT && !ext_mode_r && int_tick && !int_end) begin
         sck_drv_r <= !sck_drv_r;
      end
   end

   // pin drivers
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         sck_out <= 1'b1;
         sck_oe_r <= 1'b0;
         sck_pullup_out <= 1'b1;
      end else begin
         sck_out <= sck_drv_r;
         sck_oe_r <= !ext_mode_r && !cs_n_in && state_r != ST_POR;
         sck_pullup_out <= (state_r == ST_POR) || (cs_rise && sck_oe_r) || sck_in;
      end
   end
   assign sck_oe_out = sck_oe_r;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         sdo_out <= EOC_BUSY;
         sdo_oe_out <= 1'b0;
      end else begin
         sdo_oe_out <= !cs_n_in;
         case (state_r)
            ST_SLEEP: sdo_out <= EOC_DONE;
            ST_DOUT: sdo_out <= shreg_r[FRAME_BITS-1];
            default: sdo_out <= EOC_BUSY;
         endcase
      end
   end

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   a_sdo_release: assert property (cs_n_in |=> !sdo_oe_out)
      else $error("data output driven with chip select high");
   a_eoc_busy: assert property (state_r == ST_CONV |=> sdo_out)
      else $error("flag not high during conversion");
   a_eoc_sleep: assert property (state_r == ST_SLEEP |=> !sdo_out)
      else $error("flag not low in sleep");
   a_conv_to_sleep: assert property (state_r == ST_CONV && buf_valid |=> state_r == ST_SLEEP)
      else $error("finished conversion did not enter sleep");
   a_mode_sample: assert property (cs_fall && state_r != ST_POR |=> ext_mode_r == !$past(sck_in))
      else $error("clock mode not taken at chip-select fall");
   a_ext_restart: assert property (ext_end |=> state_r == ST_CONV ##1 sdo_out)
      else $error("32nd fall did not restart conversion");
   a_abort_start: assert property (abort |=> state_r == ST_CONV && conv_start_out)
      else $error("abort did not start a conversion");
   a_pullup_low: assert property (!sck_in && state_r != ST_POR && !(cs_rise && sck_oe_r) |=> !sck_pullup_out)
      else $error("pull-up on while clock low");
   a_poll_asleep: assert property (state_r == ST_SLEEP && !ext_mode_r && !tdly_expired |=> state_r != ST_DOUT)
      else $error("output began before the test delay");
   a_int_drive: assert property (!ext_mode_r && !cs_n_in && state_r == ST_CONV |=> sck_oe_out)
      else $error("internal clock not driven with chip select low");
   a_frame_len: assert property (state_r == ST_DOUT |-> bit_cnt_r <= LAST_BIT)
      else $error("more than 32 clock rises in one frame");
   a_int_hold: assert property (int_end |=> sck_drv_r ##1 (sck_out && (sck_drv_r || state_r == ST_SLEEP)))
      else $error("clock not held high after the 32nd rise");

   c_ext_frame: cover property (ext_end);
   c_int_frame: cover property (int_end);
   c_abort: cover property (abort);
   c_status_poll: cover property (state_r == ST_SLEEP && !ext_mode_r && cs_rise);
endmodule

/* test/adcsr_host_model.sv */
module adcsr_host_model (
   // device pins
   input wire logic clk_in,
   input wire logic dev_sck_in,
   input wire logic dev_sck_oe_in,
   input wire logic dev_pullup_in,
   input wire logic sdo_in,
   // host drive
   output logic cs_n_out,
   output logic sck_line_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic host_sck_r;
   logic host_oe_r;
   logic post_sdo_r;
   initial begin
      cs_n_out = 1'b1;
      host_sck_r = 1'b0;
      host_oe_r = 1'b1;
   end
   // device drive wins, then host, then weak pull-up; a line nobody pulls sits low
   assign sck_line_out = dev_sck_oe_in ? dev_sck_in : (host_oe_r ? host_sck_r : dev_pullup_in);
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   task automatic select_ext();
      host_oe_r = 1'b1;
      host_sck_r = 1'b0;
      cyc(3);
      cs_n_out = 1'b0;
      cyc(3);
   endtask
   // drive high then release so the pull-up keeps the line high across the fall
   task automatic select_int();
      host_oe_r = 1'b1;
      host_sck_r = 1'b1;
      cyc(3);
      host_oe_r = 1'b0;
      cyc(2);
      cs_n_out = 1'b0;
      cyc(3);
   endtask
   task automatic deselect();
      cs_n_out = 1'b1;
      cyc(3);
   endtask
   task automatic shift_ext(input int n, output logic [31:0] w);
      w = '0;
      for (int i = 0; i < n; i++) begin
         host_sck_r = 1'b1;
         cyc(3);
         w = {w[30:0], sdo_in};
         host_sck_r = 1'b0;
         cyc(2);
         post_sdo_r = sdo_in;
         cyc(1);
      end
   endtask
   task automatic shift_int(input int n, output logic [31:0] w);
      logic p;
      w = '0;
      for (int i = 0; i < n; i++) begin
         p = sck_line_out;
         for (int t = 0; t < 3000 && !(p === 1'b0 && sck_line_out === 1'b1); t++) begin
            p = sck_line_out;
            cyc(1);
         end
         w = {w[30:0], sdo_in};
      end
   endtask
endmodule

/* test/testbench.sv */
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import adcsr_pkg::*;
   logic clk_in = 1'b0;
   logic rst_in;
   logic conv_tick_in = 1'b0;
   logic rate_oscillator_pin_in;
   logic result_valid_in;
   logic [30:0] result_data_in;
   logic cs_n_in, sck_in, sck_out, sck_oe_out, sck_pullup_out, sdo_out, sdo_oe_out;
   logic conv_start_out, result_ready_out;
   logic [31:0] lfsr_r = 32'h43f8;
   logic [30:0] words[$];
   int err_count = 0;
   int compares = 0;
   int nconv = 0;
   bit core_en = 1'b0;
   bit taken = 1'b0;
   adcsr_readout #(.POR_CYCLES(20)) u_adcsr_readout (.clk_in(clk_in), .rst_in(rst_in), .cs_n_in(cs_n_in),
      .sck_in(sck_in), .sck_out(sck_out), .sck_oe_out(sck_oe_out), .sck_pullup_out(sck_pullup_out),
      .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out), .rate_oscillator_pin_in(rate_oscillator_pin_in),
      .conv_tick_in(conv_tick_in), .conv_start_out(conv_start_out), .result_valid_in(result_valid_in),
      .result_data_in(result_data_in), .result_ready_out(result_ready_out));
   adcsr_host_model u_adcsr_host_model (.clk_in(clk_in), .dev_sck_in(sck_out), .dev_sck_oe_in(sck_oe_out),
      .dev_pullup_in(sck_pullup_out), .sdo_in(sdo_out), .cs_n_out(cs_n_in), .sck_line_out(sck_in));
   initial begin
      forever #20 clk_in = ~clk_in;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic [31:0] exp_frame(input int k);
      return {1'b0, words[k]};
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wait_sdo(input logic v);
      for (int t = 0; t < 20000 && sdo_out !== v; t++) @(negedge clk_in);
      check(32'(sdo_out), 32'(v));
   endtask
   task automatic finish_test();
      if (err_count == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // core side: words taken on valid and ready, conversions counted
   always @(posedge clk_in) begin
      if (result_valid_in && result_ready_out) begin
         words.push_back(result_data_in);
         taken = 1'b1;
      end
      if (conv_start_out) nconv++;
   end
   always @(negedge clk_in) begin
      conv_tick_in = ~conv_tick_in;
      lfsr_r = lfsr(lfsr_r);
      if (taken || result_valid_in !== 1'b1) begin
         taken = 1'b0;
         result_valid_in = core_en && lfsr_r[3];
         result_data_in = lfsr_r[30:0];
      end
   end
   initial begin
      repeat (60000) @(posedge clk_in);
      err_count++;
      finish_test();
   end
   initial begin
      logic [31:0] w;
      logic [31:0] e;
      int k;
      rst_in = 1'b1;
      rate_oscillator_pin_in = 1'b0;
      repeat (20) @(negedge clk_in);
      rst_in = 1'b0;
      u_adcsr_host_model.select_ext();
      u_adcsr_host_model.cyc(30);
      check(32'({sdo_oe_out, sdo_out}), 32'h3);
      core_en = 1'b1;
      wait_sdo(1'b0);
      u_adcsr_host_model.cyc(60);
      check(32'({sdo_out, result_ready_out}), 32'h0);
      k = nconv;
      u_adcsr_host_model.shift_ext(32, w);
      u_adcsr_host_model.cyc(3);
      check(w, exp_frame(k - 1));
      check(32'(u_adcsr_host_model.post_sdo_r), 32'h1);
      check(32'(nconv), 32'(k + 1));
      wait_sdo(1'b0);
      k = nconv;
      e = exp_frame(k - 1);
      u_adcsr_host_model.shift_ext(8, w);
      u_adcsr_host_model.deselect();
      check(32'(w[7:0]), 32'(e[31:24]));
      check(32'(nconv), 32'(k + 1));
      check(32'(sdo_oe_out), 32'h0);
      u_adcsr_host_model.select_int();
      check(32'({sck_oe_out, sck_out}), 32'h2);
      k = nconv;
      u_adcsr_host_model.shift_int(32, w);
      u_adcsr_host_model.cyc(1);
      check(w, exp_frame(k - 1));
      check(32'({sck_out, sdo_out}), 32'h3);
      check(32'(nconv), 32'(k + 1));
      u_adcsr_host_model.deselect();
      u_adcsr_host_model.cyc(100);
      k = nconv;
      u_adcsr_host_model.select_int();
      check(32'({sck_oe_out, sck_out, sdo_out}), 32'h4);
      u_adcsr_host_model.deselect();
      check(32'(sck_pullup_out), 32'h1);
      rate_oscillator_pin_in = 1'b1;
      u_adcsr_host_model.select_int();
      u_adcsr_host_model.shift_int(32, w);
      check(w, exp_frame(k - 1));
      u_adcsr_host_model.deselect();
      u_adcsr_host_model.cyc(100);
      u_adcsr_host_model.select_int();
      k = nconv;
      u_adcsr_host_model.shift_int(5, w);
      u_adcsr_host_model.deselect();
      check(32'(nconv), 32'(k + 1));
      core_en = 1'b0;
      rate_oscillator_pin_in = 1'b0;
      u_adcsr_host_model.select_ext();
      repeat (4) begin
         u_adcsr_host_model.cyc(10);
         if (sdo_out === 1'b0) u_adcsr_host_model.shift_ext(32, w);
      end
      u_adcsr_host_model.cyc(50);
      check(32'({sdo_out, result_ready_out}), 32'h3);
      finish_test();
   end
endmodule
